// >>> pkg/pus_pkg.sv
// precision-time unit index and gpio event status: shared constants and types
// assumes a 12-bit byte address space seen through an axi4-lite slave
package pus_pkg;

   // ******************************
   // register map
   // ******************************
   localparam int unsigned PUS_ADDR_W = 12;
   localparam logic [11:0] PUS_OFS_UNIT_SELECT = 12'h520;
   localparam logic [11:0] PUS_OFS_FIRE_FLAGS = 12'h524;
   localparam logic [11:0] PUS_OFS_EVENT_FLAGS = 12'h528;
   localparam logic [11:0] PUS_OFS_EVENT_MASK = 12'h5c0;
   localparam logic [11:0] PUS_OFS_WIN_LO = 12'h52c;
   localparam logic [11:0] PUS_OFS_WIN_HI = 12'h5b3;

   // ******************************
   // field layout and reset values
   // ******************************
   localparam int unsigned PUS_STAMP_SEL_BIT = 8;
   localparam int unsigned PUS_FIRE_SEL_LSB = 0;
   localparam int unsigned PUS_FIRE_ERR_LSB = 16;
   localparam int unsigned PUS_FIRE_DONE_LSB = 0;
   localparam int unsigned PUS_FIRE_INT_LSB = 16;
   localparam int unsigned PUS_STAMP_INT_LSB = 0;
   localparam int unsigned PUS_NUM_FIRE = 3;
   localparam int unsigned PUS_NUM_STAMP = 2;
   localparam logic [1:0] PUS_FIRE_SEL_RSVD = 2'h3;
   localparam logic PUS_STAMP_SEL_RST = 1'h0;
   localparam logic [1:0] PUS_FIRE_SEL_RST = 2'h0;
   localparam logic [2:0] PUS_FIRE_FLAG_RST = 3'h0;
   localparam logic [1:0] PUS_STAMP_FLAG_RST = 2'h0;
   localparam logic [31:0] PUS_MASK_RST = 32'h0000_0000;

   // ******************************
   // bus answers
   // ******************************
   localparam logic [1:0] PUS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PUS_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } pus_wr_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic [1:0] fire_unit;
      logic stamp_unit;
   } pus_win_s;

   function automatic logic [31:0] pus_byte_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   function automatic logic pus_in_window(input logic [11:0] a);
      return (a >= PUS_OFS_WIN_LO) && (a <= PUS_OFS_WIN_HI);
   endfunction

endpackage

// >>> design/pus_axil_slave.sv
// axi4-lite slave front end: one write and one read in flight at a time
// assumes the register core decodes combinationally in the strobe cycle
`timescale 1ns/100ps
module pus_axil_slave
   import pus_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output pus_wr_s wr_req,
   output logic wr_stb,
   input wire logic wr_ok,
   output logic [11:0] rd_addr,
   output logic rd_stb,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   logic aw_held_ff, w_held_ff, bvalid_ff, ar_held_ff, rvalid_ff;
   logic [11:0] awaddr_ff, araddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;

   assign s_axi_awready = !aw_held_ff && !bvalid_ff;
   assign s_axi_wready = !w_held_ff && !bvalid_ff;
   assign s_axi_arready = !ar_held_ff && !rvalid_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   assign wr_stb = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wr_req = '{addr: {awaddr_ff[11:2], 2'h0}, data: wdata_ff, strb: wstrb_ff};
   assign rd_stb = ar_held_ff && !rvalid_ff;
   assign rd_addr = {araddr_ff[11:2], 2'h0};

   // ******************************
   // write path
   // ******************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= PUS_RESP_OKAY;
         awaddr_ff <= 12'h000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_stb) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? PUS_RESP_OKAY : PUS_RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ******************************
   // read path
   // ******************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         ar_held_ff <= 1'b0;
         araddr_ff <= 12'h000;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= PUS_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_held_ff <= 1'b1;
            araddr_ff <= s_axi_araddr;
         end
         if (rd_stb) begin
            ar_held_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_ok ? rd_data : 32'h0000_0000;
            rresp_ff <= rd_ok ? PUS_RESP_OKAY : PUS_RESP_SLVERR;
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

endmodule // pus_axil_slave

// >>> design/pus_event_regs.sv
// precision-time unit index, trigger error/done flags and gpio event interrupt flags
// assumes the trigger and timestamp engines sit outside and answer the indexed window
`timescale 1ns/100ps
module pus_event_regs
   import pus_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [2:0] fire_err_evt,
   input wire logic [2:0] fire_done_evt,
   input wire logic [2:0] fire_report_enable,
   input wire logic [2:0] fire_enable_wr_zero,
   input wire logic [1:0] stamp_evt,
   input wire logic [1:0] stamp_int_enable,
   output pus_win_s win,
   input wire logic [31:0] win_rdata,
   output logic stamp_unit_select,
   output logic [1:0] fire_unit_select,
   output logic gpio_event_any,
   output logic irq
);

   pus_wr_s wr_req;
   logic wr_stb, wr_ok, rd_stb, rd_ok;
   logic [11:0] rd_addr;
   logic [31:0] rd_data, wmask;

   logic stamp_sel_ff;
   logic [1:0] fire_sel_ff;
   logic [2:0] fire_err_ff, fire_done_ff, fire_int_ff;
   logic [1:0] stamp_int_ff;
   logic [31:0] mask_ff;

   logic [2:0] err_set, done_set, fire_int_set;
   logic [1:0] stamp_int_set;
   logic [2:0] err_clr, done_clr, fire_int_clr;
   logic [1:0] stamp_int_clr;
   logic [31:0] fire_flags_word, event_flags_word;

   pus_axil_slave u_slave (
      .mclk(mclk),
      .reset(reset),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_req(wr_req),
      .wr_stb(wr_stb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_stb(rd_stb),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ******************************
   // indexed window steering
   // ******************************
   assign stamp_unit_select = stamp_sel_ff;
   assign fire_unit_select = fire_sel_ff;
   always_comb begin
      win.wr = wr_stb && pus_in_window(wr_req.addr);
      win.rd = rd_stb && pus_in_window(rd_addr);
      win.addr = win.wr ? wr_req.addr : rd_addr;
      win.data = wr_req.data;
      win.strb = wr_req.strb;
      win.fire_unit = fire_sel_ff;
      win.stamp_unit = stamp_sel_ff;
   end

   // ******************************
   // unit select register
   // ******************************
   assign wmask = pus_byte_mask(wr_req.strb);
   always_ff @(posedge mclk) begin
      if (reset) begin
         stamp_sel_ff <= PUS_STAMP_SEL_RST;
         fire_sel_ff <= PUS_FIRE_SEL_RST;
      end else if (wr_stb && wr_req.addr == PUS_OFS_UNIT_SELECT) begin
         if (wmask[PUS_STAMP_SEL_BIT]) begin
            stamp_sel_ff <= wr_req.data[PUS_STAMP_SEL_BIT];
         end
         // the reserved code would address no unit, so it is dropped
         if (wmask[PUS_FIRE_SEL_LSB] &&
             wr_req.data[PUS_FIRE_SEL_LSB +: 2] != PUS_FIRE_SEL_RSVD) begin
            fire_sel_ff <= wr_req.data[PUS_FIRE_SEL_LSB +: 2];
         end
      end
   end

   // ******************************
   // sticky flags, set wins over clear
   // ******************************
   always_comb begin
      err_set = fire_err_evt & fire_report_enable;
      done_set = fire_done_evt & fire_report_enable;
      fire_int_set = err_set | done_set;
      stamp_int_set = stamp_evt & stamp_int_enable;
      err_clr = fire_enable_wr_zero;
      done_clr = 3'h0;
      fire_int_clr = 3'h0;
      stamp_int_clr = 2'h0;
      if (wr_stb && wr_req.addr == PUS_OFS_FIRE_FLAGS) begin
         err_clr = err_clr | (wr_req.data[PUS_FIRE_ERR_LSB +: 3]
                              & wmask[PUS_FIRE_ERR_LSB +: 3]);
         done_clr = wr_req.data[PUS_FIRE_DONE_LSB +: 3] & wmask[PUS_FIRE_DONE_LSB +: 3];
      end
      if (wr_stb && wr_req.addr == PUS_OFS_EVENT_FLAGS) begin
         fire_int_clr = wr_req.data[PUS_FIRE_INT_LSB +: 3] & wmask[PUS_FIRE_INT_LSB +: 3];
         stamp_int_clr = wr_req.data[PUS_STAMP_INT_LSB +: 2]
                         & wmask[PUS_STAMP_INT_LSB +: 2];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         fire_err_ff <= PUS_FIRE_FLAG_RST;
         fire_done_ff <= PUS_FIRE_FLAG_RST;
      end else begin
         fire_err_ff <= (fire_err_ff & ~err_clr) | err_set;
         fire_done_ff <= (fire_done_ff & ~done_clr) | done_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         fire_int_ff <= PUS_FIRE_FLAG_RST;
         stamp_int_ff <= PUS_STAMP_FLAG_RST;
      end else begin
         fire_int_ff <= (fire_int_ff & ~fire_int_clr) | fire_int_set;
         stamp_int_ff <= (stamp_int_ff & ~stamp_int_clr) | stamp_int_set;
      end
   end

   // ******************************
   // interrupt mask and outputs
   // ******************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         mask_ff <= PUS_MASK_RST;
      end else if (wr_stb && wr_req.addr == PUS_OFS_EVENT_MASK) begin
         mask_ff <= (mask_ff & ~wmask) | (wr_req.data & wmask);
      end
   end

   always_comb begin
      fire_flags_word = 32'h0000_0000;
      fire_flags_word[PUS_FIRE_ERR_LSB +: 3] = fire_err_ff;
      fire_flags_word[PUS_FIRE_DONE_LSB +: 3] = fire_done_ff;
      event_flags_word = 32'h0000_0000;
      event_flags_word[PUS_FIRE_INT_LSB +: 3] = fire_int_ff;
      event_flags_word[PUS_STAMP_INT_LSB +: 2] = stamp_int_ff;
   end

   assign gpio_event_any = |fire_int_ff || |stamp_int_ff;
   // mask bits outside the flag layout have no flag behind them
   assign irq = |(event_flags_word & mask_ff);

   // ******************************
   // read and write decode
   // ******************************
   always_comb begin
      rd_ok = 1'b1;
      if (rd_addr == PUS_OFS_UNIT_SELECT) begin
         rd_data = 32'h0000_0000;
         rd_data[PUS_STAMP_SEL_BIT] = stamp_sel_ff;
         rd_data[PUS_FIRE_SEL_LSB +: 2] = fire_sel_ff;
      end else if (rd_addr == PUS_OFS_FIRE_FLAGS) begin
         rd_data = fire_flags_word;
      end else if (rd_addr == PUS_OFS_EVENT_FLAGS) begin
         rd_data = event_flags_word;
      end else if (rd_addr == PUS_OFS_EVENT_MASK) begin
         rd_data = mask_ff;
      end else if (pus_in_window(rd_addr)) begin
         rd_data = win_rdata;
      end else begin
         rd_data = 32'h0000_0000;
         rd_ok = 1'b0;
      end
   end

   always_comb begin
      if (wr_req.addr == PUS_OFS_UNIT_SELECT || wr_req.addr == PUS_OFS_FIRE_FLAGS) begin
         wr_ok = 1'b1;
      end else if (wr_req.addr == PUS_OFS_EVENT_FLAGS || wr_req.addr == PUS_OFS_EVENT_MASK) begin
         wr_ok = 1'b1;
      end else if (pus_in_window(wr_req.addr)) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   // ******************************
   // assertions
   // ******************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence seq_sel_write;
      wr_stb && wr_req.addr == PUS_OFS_UNIT_SELECT;
   endsequence

   sequence seq_fire_flag_write;
      wr_stb && wr_req.addr == PUS_OFS_FIRE_FLAGS;
   endsequence

   sequence seq_event_flag_write;
      wr_stb && wr_req.addr == PUS_OFS_EVENT_FLAGS;
   endsequence

   AST_WIN_STEER: assert property ((win.wr || win.rd) |->
         pus_in_window(win.addr) && win.fire_unit != PUS_FIRE_SEL_RSVD &&
         win.fire_unit == fire_unit_select && win.stamp_unit == stamp_unit_select)
      else $error("window access not steered to selected units");

   AST_STAMP_SEL: assert property ((seq_sel_write and (wr_req.strb[1])) |=>
         stamp_unit_select == $past(wr_req.data[8]))
      else $error("timestamp unit select did not follow write");

   AST_FIRE_SEL_RSVD: assert property ((seq_sel_write and
         (wr_req.data[1:0] == 2'h3)) |=> $stable(fire_unit_select))
      else $error("reserved trigger select code was taken");

   AST_ERR_SET: assert property ((err_set != 3'h0) |=>
         ((fire_err_ff & $past(err_set)) == $past(err_set)) && gpio_event_any)
      else $error("trigger error flag or interrupt missing");

   AST_ERR_HOLD: assert property ((fire_err_ff[0] && !err_clr[0]) |=>
         fire_err_ff[0])
      else $error("trigger error flag dropped without clear");

   AST_DONE_SET: assert property (done_set[2] |=>
         fire_done_ff[2] && fire_int_ff[2])
      else $error("trigger done flag or interrupt missing");

   AST_DONE_CLEAR: assert property ((seq_fire_flag_write and (wr_req.data[0] &&
         wr_req.strb[0] && !done_set[0])) |=> !fire_done_ff[0])
      else $error("trigger done flag not cleared by write");

   AST_FIRE_INT_GATE: assert property ((!fire_int_ff[1] &&
         (fire_err_evt[1] || fire_done_evt[1]) && !fire_report_enable[1])
         |=> !fire_int_ff[1])
      else $error("trigger interrupt set while not reporting");

   AST_STAMP_INT: assert property ((!stamp_int_ff[1] && stamp_evt[1] &&
         !stamp_int_enable[1]) |=> !stamp_int_ff[1])
      else $error("timestamp interrupt set while disabled");

   AST_INT_CLEAR: assert property ((seq_event_flag_write and
         (wr_req.strb[2] && wr_req.strb[0]) and
         ((wr_req.data & event_flags_word) == event_flags_word) and (fire_int_set == 3'h0) and
         (stamp_int_set == 2'h0)) |=> !gpio_event_any)
      else $error("interrupt flags not cleared by write");

   AST_SET_WINS: assert property ((stamp_int_set[0] && stamp_int_clr[0]) |=>
         stamp_int_ff[0])
      else $error("set lost against clear");

   AST_RSVD_ZERO: assert property ((rd_stb && rd_addr == PUS_OFS_EVENT_FLAGS) |=>
         s_axi_rdata[31:19] == 13'h0000 && s_axi_rdata[15:2] == 14'h0000)
      else $error("reserved bits read nonzero");

endmodule // pus_event_regs

// >>> verif/test_ptp_unit_index_and_gpio_event_status.sv
// self-checking bench for the unit index, trigger flags and gpio event interrupt flags
// assumes pus_event_regs as the top, driven alone over axi4-lite with event pulses beside it
`timescale 1ns/100ps
module test_ptp_unit_index_and_gpio_event_status
   import pus_pkg::*;
;
   // ******************************
   // signals
   // ******************************
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic [1:0] r;
   } pus_row_s;
   localparam int LIMIT = 20000;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [11:0] s_axi_araddr = 12'h000;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [2:0] fire_err_evt = 3'h0;
   logic [2:0] fire_done_evt = 3'h0;
   logic [2:0] fire_report_enable = 3'h5;
   logic [2:0] fire_enable_wr_zero = 3'h0;
   logic [1:0] stamp_evt = 2'h0;
   logic [1:0] stamp_int_enable = 2'h1;
   pus_win_s win;
   pus_win_s cap;
   logic [31:0] win_rdata = 32'ha5c3_0f1e;
   logic stamp_unit_select;
   logic [1:0] fire_unit_select;
   logic gpio_event_any;
   logic irq;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   pus_row_s rows [8];

   always #25 mclk = ~mclk;

   pus_event_regs dut_u (
      .mclk(mclk), .reset(reset),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .fire_err_evt(fire_err_evt), .fire_done_evt(fire_done_evt),
      .fire_report_enable(fire_report_enable), .fire_enable_wr_zero(fire_enable_wr_zero),
      .stamp_evt(stamp_evt), .stamp_int_enable(stamp_int_enable), .win(win),
      .win_rdata(win_rdata), .stamp_unit_select(stamp_unit_select),
      .fire_unit_select(fire_unit_select), .gpio_event_any(gpio_event_any), .irq(irq)
   );

   // last forwarded window access, kept for comparison after the bus answer
   always @(posedge mclk) begin
      if (win.wr === 1'b1 || win.rd === 1'b1) begin
         cap <= win;
      end
   end

   // ******************************
   // checking and closing
   // ******************************
   task summarize();
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // a hang anywhere ends up here
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         summarize();
      end
   end

   // ******************************
   // bus and event drivers
   // ******************************
   // ready is looked at mid-cycle, so the handshake edge is the next rising one
   task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic pa;
      logic pw;
      logic ta;
      logic tw;
      logic tb;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      tb = 1'b0;
      while (pa || pw || !tb) begin
         @(negedge mclk);
         ta = pa & s_axi_awready;
         tw = pw & s_axi_wready;
         tb = !pa && !pw && (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge mclk);
         if (ta) begin
            s_axi_awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            s_axi_wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      s_axi_bready <= 1'b0;
   endtask

   task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic pa;
      logic tr;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      pa = 1'b1;
      tr = 1'b0;
      while (pa || !tr) begin
         @(negedge mclk);
         tr = !pa && (s_axi_rvalid === 1'b1);
         d = s_axi_rdata;
         resp = s_axi_rresp;
         if (pa && s_axi_arready) begin
            pa = 1'b0;
            @(posedge mclk);
            s_axi_arvalid <= 1'b0;
         end else begin
            @(posedge mclk);
         end
      end
      s_axi_rready <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk({30'h0, r}, {30'h0, PUS_RESP_OKAY});
   endtask

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(d, exp);
      chk({30'h0, r}, {30'h0, PUS_RESP_OKAY});
   endtask

   task ev(input logic [2:0] e, input logic [2:0] dn, input logic [2:0] z, input logic [1:0] s);
      @(posedge mclk);
      fire_err_evt <= e;
      fire_done_evt <= dn;
      fire_enable_wr_zero <= z;
      stamp_evt <= s;
      @(posedge mclk);
      fire_err_evt <= 3'h0;
      fire_done_evt <= 3'h0;
      fire_enable_wr_zero <= 3'h0;
      stamp_evt <= 2'h0;
   endtask

   task lvl(input logic any_exp, input logic irq_exp);
      @(negedge mclk);
      chk({31'h0, gpio_event_any}, {31'h0, any_exp});
      chk({31'h0, irq}, {31'h0, irq_exp});
   endtask

   // ******************************
   // main sequence
   // ******************************
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      rows = '{
         '{12'h520, 32'hffff_ff01, 32'h0000_0101, PUS_RESP_OKAY},
         '{12'h520, 32'h0000_0103, 32'h0000_0101, PUS_RESP_OKAY},
         '{12'h520, 32'h0000_0002, 32'h0000_0002, PUS_RESP_OKAY},
         '{12'h524, 32'hffff_ffff, 32'h0000_0000, PUS_RESP_OKAY},
         '{12'h528, 32'hffff_ffff, 32'h0000_0000, PUS_RESP_OKAY},
         '{12'h5c0, 32'h1234_5678, 32'h1234_5678, PUS_RESP_OKAY},
         '{12'h5c0, 32'h0007_0003, 32'h0007_0003, PUS_RESP_OKAY},
         '{12'h600, 32'hffff_ffff, 32'h0000_0000, PUS_RESP_SLVERR}};
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      lvl(1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         axw(rows[i].a, rows[i].d, r);
         chk({30'h0, r}, {30'h0, rows[i].r});
         axr(rows[i].a, d, r);
         chk(d, rows[i].x);
         chk({30'h0, r}, {30'h0, rows[i].r});
      end
      chk({29'h0, stamp_unit_select, fire_unit_select}, 32'h2);
      $display("test table done");
      // window accesses go to the selected pair of units
      wr(12'h520, 32'h0000_0101);
      chk({29'h0, stamp_unit_select, fire_unit_select}, 32'h5);
      wr(12'h530, 32'hcafe_0530);
      chk({cap.wr, cap.rd, cap.stamp_unit, cap.fire_unit, 15'h0, cap.addr}, 32'ha800_0530);
      chk(cap.data, 32'hcafe_0530);
      chk({28'h0, cap.strb}, 32'h0000_000f);
      rd_chk(12'h52c, 32'ha5c3_0f1e);
      chk({cap.wr, cap.rd, cap.stamp_unit, cap.fire_unit, 15'h0, cap.addr}, 32'h6800_052c);
      // only byte lane 0 written, the timestamp select must keep its value
      s_axi_wstrb <= 4'h1;
      wr(12'h520, 32'h0000_0002);
      s_axi_wstrb <= 4'hf;
      rd_chk(12'h520, 32'h0000_0102);
      $display("test window done");
      // units 1 and timestamp 1 have reporting off and must stay silent
      ev(3'h7, 3'h0, 3'h0, 2'h0);
      rd_chk(12'h524, 32'h0005_0000);
      rd_chk(12'h528, 32'h0005_0000);
      lvl(1'b1, 1'b1);
      ev(3'h0, 3'h7, 3'h0, 2'h0);
      rd_chk(12'h524, 32'h0005_0005);
      ev(3'h0, 3'h0, 3'h0, 2'h3);
      rd_chk(12'h528, 32'h0005_0001);
      wr(12'h524, 32'h0001_0001);
      rd_chk(12'h524, 32'h0004_0004);
      ev(3'h0, 3'h0, 3'h4, 2'h0);
      rd_chk(12'h524, 32'h0000_0004);
      wr(12'h528, 32'h0004_0000);
      rd_chk(12'h528, 32'h0001_0001);
      lvl(1'b1, 1'b1);
      wr(12'h5c0, 32'h0000_0000);
      lvl(1'b1, 1'b0);
      wr(12'h528, 32'h0001_0001);
      rd_chk(12'h528, 32'h0000_0000);
      lvl(1'b0, 1'b0);
      // event pulse lands in the clear strobe cycle: the set must win
      fork
         wr(12'h528, 32'h0000_0001);
         begin
            repeat (2) @(posedge mclk);
            stamp_evt <= 2'h1;
            @(posedge mclk);
            stamp_evt <= 2'h0;
         end
      join
      rd_chk(12'h528, 32'h0000_0001);
      lvl(1'b1, 1'b0);
      $display("test events done");
      // reset in mid-run with state and flags set
      wr(12'h520, 32'h0000_0102);
      wr(12'h5c0, 32'h0007_0003);
      ev(3'h1, 3'h1, 3'h0, 2'h1);
      lvl(1'b1, 1'b1);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      rd_chk(12'h520, 32'h0000_0000);
      rd_chk(12'h524, 32'h0000_0000);
      rd_chk(12'h528, 32'h0000_0000);
      rd_chk(12'h5c0, 32'h0000_0000);
      chk({29'h0, stamp_unit_select, fire_unit_select}, 32'h0);
      lvl(1'b0, 1'b0);
      $display("test reset done");
      summarize();
   end
endmodule // test_ptp_unit_index_and_gpio_event_status
